// ### hw/epc_pkg.sv
package epc_pkg;
  localparam logic [15:0] EPC_PROGRAM_CONTROL_ADDR = 16'h103B;
  localparam logic [15:0] EPC_SEPARATE_CTRL_ADDR   = 16'h1036;
  localparam logic [15:0] EPC_ROUTINE_START        = 16'hBF00;
  localparam logic [15:0] EPC_DEST_DEFAULT         = 16'hD000;
  localparam logic [15:0] EPC_DELAY_DEFAULT        = 16'h0FA0;
  localparam logic [7:0]  EPC_READY_BYTE           = 8'hFF;
  localparam logic [7:0]  EPC_ERASED_BYTE          = 8'hFF;
  localparam logic [7:0]  EPC_CTRL_RESET           = 8'h00;
  localparam int          EPC_PROG_LATCH_POS       = 5;
  localparam int          EPC_EE_LATCH_POS         = 1;
  localparam int          EPC_VOLT_POS             = 0;
  localparam int          EPC_MEM_AW               = 15;
  localparam int          EPC_MEM_DEPTH            = 32768;
  localparam logic [15:0] EPC_MEM_BASE             = 16'h8000;
  localparam logic        EPC_CTRL_COMBINED        = 1'b0;
  localparam logic        EPC_CTRL_SEPARATE        = 1'b1;
  typedef enum logic [1:0] {EPC_IDLE, EPC_READY, EPC_RUN} epc_boot_t;
endpackage

// ### hw/epc_array.sv
`timescale 1ns/1ps
`default_nettype none
module epc_array
  import epc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 prog_en,
  input  wire logic [EPC_MEM_AW-1:0] prog_addr,
  input  wire logic [7:0]           prog_data,
  input  wire logic [EPC_MEM_AW-1:0] rd_addr,
  output logic      [7:0]           rd_data
);
  // Array cells start erased; programming can only clear bits
  logic [7:0] mem [0:EPC_MEM_DEPTH-1] = '{default: EPC_ERASED_BYTE};
  always_ff @(posedge clk)
  begin
    if (prog_en)
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ### hw/epc_ctrl.sv
// Operation
// - Latch bit set: reads blocked; memory writes capture address and data only while the voltage bit is clear
// - Latch bit always readable; its writes ignored while voltage enabled
// - Latch bit 0 gives normal reads, 1 gives programming paths
// - Combined register: memory latch and EEPROM latch never both set
// - Voltage bit always readable; writable only when a latch bit is set
// - Voltage bit 1 connects programming voltage, 0 disconnects it
// - Combined register: one voltage bit gates memory and EEPROM voltage
// - Erased cells read ones; programming only clears bits
// - Separate variant: memory programming in its own dedicated register
// - Resident routine at 0xBF00; default delay index, pointer 0xD000
// - Writing EEPROM latch and voltage together while EEPROM latch clear leaves both cleared
// - EEPROM latch clear: EEPROM normal reads, no EEPROM programming
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl
  import epc_pkg::*;
#(
  parameter logic VARIANT = EPC_CTRL_COMBINED
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             mem_rd_blocked,
  output logic             prog_vpp_on,
  output logic             ee_vpp_on,
  output logic             ee_latch_active,
  output logic      [15:0] latched_addr,
  output logic      [7:0]  latched_data,
  input  wire logic        boot_start,
  input  wire logic        special_mode,
  output logic      [15:0] routine_entry,
  output logic      [15:0] delay_index,
  output logic      [15:0] destination_pointer,
  output logic      [7:0]  host_tx_data,
  output logic             host_tx_valid,
  input  wire logic [7:0]  host_rx_data,
  input  wire logic        host_rx_valid
);
  logic [7:0]  pc_ff, nxt_pc;
  logic [7:0]  sep_ff, nxt_sep;
  logic [15:0] la_ff, nxt_la;
  logic [7:0]  ld_ff, nxt_ld;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        vpp_d_ff;
  epc_boot_t   bst_ff, nxt_bst;
  logic [15:0] dst_ff, nxt_dst;
  logic [7:0]  tx_ff, nxt_tx;
  logic        txv_ff, nxt_txv;
  logic        echo_ff, nxt_echo;
  logic        echo2_ff, nxt_echo2;
  logic [7:0]  mem_q;
  logic        wr_mem;

  function automatic logic in_mem(input logic [15:0] a);
    in_mem = a >= EPC_MEM_BASE;
  endfunction

  // Control bits selected by variant
  logic [7:0] mctl;
  logic       m_lat, e_lat, m_volt, e_volt;
  always_comb
  begin
    mctl   = (VARIANT == EPC_CTRL_SEPARATE) ? sep_ff : pc_ff;
    m_lat  = mctl[EPC_PROG_LATCH_POS];
    m_volt = mctl[EPC_VOLT_POS];
    e_lat  = pc_ff[EPC_EE_LATCH_POS];
    e_volt = pc_ff[EPC_VOLT_POS];
  end

  // Register write interlocks
  function automatic logic [7:0] ctl_write(input logic [7:0] cur,
                                          input logic [7:0] wd,
                                          input logic       has_ee);
    logic [7:0] r;
    r = wd;
    if (cur[EPC_VOLT_POS])
      r[EPC_PROG_LATCH_POS] = cur[EPC_PROG_LATCH_POS];
    if (!(cur[EPC_PROG_LATCH_POS] || (has_ee && cur[EPC_EE_LATCH_POS])))
      r[EPC_VOLT_POS] = cur[EPC_VOLT_POS];
    if (has_ee && wd[EPC_EE_LATCH_POS] && wd[EPC_VOLT_POS]
        && !cur[EPC_EE_LATCH_POS])
    begin
      r[EPC_EE_LATCH_POS] = 1'b0;
      r[EPC_VOLT_POS]     = 1'b0;
    end
    if (has_ee && r[EPC_PROG_LATCH_POS] && r[EPC_EE_LATCH_POS])
      r[EPC_EE_LATCH_POS] = 1'b0;
    if (!has_ee)
      r[EPC_EE_LATCH_POS] = 1'b0;
    ctl_write = r;
  endfunction

  always_comb
  begin
    nxt_pc  = pc_ff;
    nxt_sep = sep_ff;
    if (bus_wr && bus_addr == EPC_PROGRAM_CONTROL_ADDR)
      nxt_pc = ctl_write(pc_ff, bus_wdata, 1'b1);
    if (VARIANT == EPC_CTRL_SEPARATE && bus_wr
        && bus_addr == EPC_SEPARATE_CTRL_ADDR)
      nxt_sep = ctl_write(sep_ff, bus_wdata, 1'b0);
    if (VARIANT == EPC_CTRL_SEPARATE)
      nxt_pc[EPC_PROG_LATCH_POS] = 1'b0;
  end

  // Latching of program-memory writes
  always_comb
  begin
    wr_mem = bus_wr && in_mem(bus_addr) && m_lat && !m_volt;
    nxt_la = la_ff;
    nxt_ld = ld_ff;
    if (wr_mem)
    begin
      nxt_la = bus_addr;
      nxt_ld = bus_wdata;
    end
  end

  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (bus_rd)
    begin
      if (bus_addr == EPC_PROGRAM_CONTROL_ADDR)
        nxt_rdata = pc_ff;
      else if (VARIANT == EPC_CTRL_SEPARATE
               && bus_addr == EPC_SEPARATE_CTRL_ADDR)
        nxt_rdata = sep_ff;
      else
        nxt_rdata = 8'h00;
    end
  end

  // Resident download routine: ready byte, then echo each programmed byte
  always_comb
  begin
    nxt_bst  = bst_ff;
    nxt_dst  = dst_ff;
    nxt_tx   = tx_ff;
    nxt_txv  = 1'b0;
    nxt_echo = 1'b0;
    nxt_echo2 = 1'b0;
    case (bst_ff)
      EPC_IDLE:
        if (boot_start && special_mode)
        begin
          nxt_dst = EPC_DEST_DEFAULT;
          nxt_bst = EPC_READY;
        end
      EPC_READY:
      begin
        nxt_tx  = EPC_READY_BYTE;
        nxt_txv = 1'b1;
        nxt_bst = EPC_RUN;
      end
      EPC_RUN:
      begin
        if (host_rx_valid && !echo_ff && !echo2_ff)
          nxt_echo = 1'b1;
        // Array read data lag the write by one cycle, so echo a cycle later
        nxt_echo2 = echo_ff;
        if (echo2_ff)
        begin
          nxt_tx  = mem_q;
          nxt_txv = 1'b1;
          nxt_dst = dst_ff + 16'h0001;
        end
      end
      default:
        nxt_bst = EPC_IDLE;
    endcase
  end

  logic        arr_wr;
  logic [15:0] arr_a;
  logic [7:0]  arr_d;
  always_comb
  begin
    arr_wr = 1'b0;
    arr_a  = la_ff;
    arr_d  = ld_ff;
    if (bst_ff == EPC_RUN && host_rx_valid && !echo_ff && !echo2_ff)
    begin
      arr_wr = 1'b1;
      arr_a  = dst_ff;
      arr_d  = host_rx_data;
    end
    else if (m_volt && m_lat && vpp_d_ff)
      arr_wr = 1'b1;
  end

  epc_array u_array
  (
    .clk       (clk),
    .prog_en   (arr_wr),
    .prog_addr (arr_a[EPC_MEM_AW-1:0]),
    .prog_data (arr_d),
    .rd_addr   (bst_ff == EPC_RUN ? dst_ff[EPC_MEM_AW-1:0]
                                  : bus_addr[EPC_MEM_AW-1:0]),
    .rd_data   (mem_q)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pc_ff    <= EPC_CTRL_RESET;
      sep_ff   <= EPC_CTRL_RESET;
      la_ff    <= 16'h0000;
      ld_ff    <= EPC_ERASED_BYTE;
      rdata_ff <= 8'h00;
      vpp_d_ff <= 1'b0;
      bst_ff   <= EPC_IDLE;
      dst_ff   <= EPC_DEST_DEFAULT;
      tx_ff    <= 8'h00;
      txv_ff   <= 1'b0;
      echo_ff  <= 1'b0;
      echo2_ff <= 1'b0;
    end
    else
    begin
      pc_ff    <= nxt_pc;
      sep_ff   <= nxt_sep;
      la_ff    <= nxt_la;
      ld_ff    <= nxt_ld;
      rdata_ff <= nxt_rdata;
      vpp_d_ff <= m_volt;
      bst_ff   <= nxt_bst;
      dst_ff   <= nxt_dst;
      tx_ff    <= nxt_tx;
      txv_ff   <= nxt_txv;
      echo_ff  <= nxt_echo;
      echo2_ff <= nxt_echo2;
    end
  end

  always_comb
  begin
    bus_rdata           = rdata_ff;
    mem_rd_blocked      = m_lat;
    prog_vpp_on         = m_volt && m_lat;
    ee_vpp_on           = e_volt && e_lat;
    ee_latch_active     = e_lat;
    latched_addr        = la_ff;
    latched_data        = ld_ff;
    routine_entry       = EPC_ROUTINE_START;
    delay_index         = EPC_DELAY_DEFAULT;
    destination_pointer = dst_ff;
    host_tx_data        = tx_ff;
    host_tx_valid       = txv_ff;
  end
endmodule
`default_nettype wire

// ### tb/epc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module epc_chk
  import epc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        mem_rd_blocked,
  input wire logic        prog_vpp_on,
  input wire logic        ee_vpp_on,
  input wire logic        ee_latch_active,
  input wire logic        boot_start,
  input wire logic        special_mode,
  input wire logic [7:0]  host_tx_data,
  input wire logic        host_tx_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic cw = bus_wr && bus_addr == EPC_PROGRAM_CONTROL_ADDR;
  sequence s_go;
    boot_start && special_mode;
  endsequence
  sequence s_ff;
    ##2 host_tx_valid && host_tx_data == EPC_READY_BYTE;
  endsequence
  AST_LAT: assert property (cw && bus_wdata == 8'h20
    && !prog_vpp_on && !ee_vpp_on |=> mem_rd_blocked) else $error("lat");
  AST_LOCK: assert property (cw && prog_vpp_on
    && bus_wdata == 8'h00 |=> mem_rd_blocked) else $error("lock");
  AST_VREF: assert property (cw && !mem_rd_blocked
    && !ee_latch_active |=> !prog_vpp_on && !ee_vpp_on) else $error("vref");
  AST_EXCL: assert property (!(mem_rd_blocked && ee_latch_active))
    else $error("excl");
  AST_BOTH: assert property (cw && bus_wdata[1:0] == 2'b11
    && !ee_latch_active |=> !ee_latch_active && !ee_vpp_on)
    else $error("both");
  AST_EEOFF: assert property (!ee_latch_active |-> !ee_vpp_on)
    else $error("eeoff");
  AST_VPP: assert property (prog_vpp_on |-> mem_rd_blocked
    && !ee_vpp_on) else $error("vpp");
  AST_BOOT: assert property (s_go |-> s_ff) else $error("boot");
endmodule
bind epc_ctrl epc_chk i_epc_chk (.*);
`default_nettype wire

// ### tb/epc_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module epc_cpu
  import epc_pkg::*;
(
  input  wire logic       clk,
  output logic     [15:0] bus_addr,
  output logic     [7:0]  bus_wdata,
  output logic            bus_wr,
  output logic            bus_rd,
  input  wire logic [7:0] bus_rdata
);
  localparam logic [15:0] CA = EPC_PROGRAM_CONTROL_ADDR;
  initial {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
  task automatic xfer(input logic [15:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] q);
    @(posedge clk) {bus_addr, bus_wdata, bus_wr, bus_rd} <= {a, d, w, !w};
    @(posedge clk) {bus_addr, bus_wdata, bus_wr, bus_rd} <= {~a, ~d, 2'b00};
    @(negedge clk) q = bus_rdata;
  endtask
  // Voltage hold shortened from milliseconds to keep the run brief
  // Map enable and the voltage pin are taken as held by the system
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(CA, 8'h20, 1'b1, q);
    xfer(a, d, 1'b1, q);
    xfer(CA, 8'h21, 1'b1, q);
    repeat (10) @(posedge clk);
    xfer(CA, 8'h00, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// ### tb/epc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl_tb;
  import epc_pkg::*;
  localparam logic [15:0] CA = EPC_PROGRAM_CONTROL_ADDR;
  localparam logic [11:0] ROWS [12] = '{12'h208, 12'h21A, 12'h008, 12'h000,
    12'h010, 12'h030, 12'h024, 12'h035, 12'h224, 12'h228, 12'h000, 12'h000};
  logic        clk = 1'b0, nrst = 1'b0, bus_wr, bus_rd, mem_rd_blocked;
  logic        prog_vpp_on, ee_vpp_on, ee_latch_active, host_tx_valid;
  logic        boot_start = 1'b0, special_mode = 1'b0, host_rx_valid = 1'b0;
  logic [15:0] bus_addr, latched_addr, routine_entry, delay_index;
  logic [15:0] destination_pointer;
  logic [7:0]  bus_wdata, bus_rdata, latched_data, host_tx_data, q;
  logic [7:0]  host_rx_data = 8'h00;
  int          err_count = 0, n_checks = 0;
  wire logic [3:0] st = {mem_rd_blocked, ee_latch_active, prog_vpp_on,
                         ee_vpp_on};
  always #12.5 clk = ~clk;
  epc_cpu i_epc_cpu (.*);
  epc_ctrl i_epc_ctrl (.*);
  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_tx(input logic [7:0] e);
    for (int i = 0; i < 9 && host_tx_valid !== 1'b1; i++)
      @(posedge clk) #1;
    chk("tx", {host_tx_valid, host_tx_data}, {1'b1, e});
    if (host_tx_valid !== 1'b1)
      conclude;
  endtask
  task automatic send(input logic [7:0] d, e);
    @(posedge clk) {host_rx_data, host_rx_valid} <= {d, 1'b1};
    @(posedge clk) {host_rx_data, host_rx_valid} <= {~d, 1'b0};
    wait_tx(e);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk) chk("rst", st, 16'h0000);
    chk("ptr", destination_pointer, EPC_DEST_DEFAULT);
    chk("ent", routine_entry, 16'hBF00);
    chk("dly", delay_index, EPC_DELAY_DEFAULT);
    $display("reset done");
    foreach (ROWS[i])
    begin
      i_epc_cpu.xfer(CA, ROWS[i][11:4], 1'b1, q);
      chk("ctl", st, ROWS[i][3:0]);
      i_epc_cpu.xfer(CA, 8'h00, 1'b0, q);
      chk("rdb", {q[5], q[1], q[0]}, {ROWS[i][3:2], |ROWS[i][1:0]});
    end
    $display("table done");
    i_epc_cpu.prog(16'hC123, 8'hF0);
    i_epc_cpu.prog(16'hC123, 8'h3C);
    chk("lat", {latched_addr[7:0], latched_data}, 16'h233C);
    chk("off", st, 16'h0008);
    $display("program done");
    @(posedge clk) {special_mode, boot_start} <= 2'b11;
    @(posedge clk) boot_start <= 1'b0;
    wait_tx(EPC_READY_BYTE);
    send(8'h5A, 8'h5A);
    send(8'hA5, 8'hA5);
    chk("inc", destination_pointer, 16'hD002);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    @(negedge clk) chk("end", destination_pointer, 16'hD000);
    chk("rst2", st, 16'h0000);
    @(posedge clk) boot_start <= 1'b1;
    @(posedge clk) boot_start <= 1'b0;
    wait_tx(EPC_READY_BYTE);
    send(8'h0F, 8'h0A);
    $display("boot done");
    conclude;
  end
endmodule
`default_nettype wire
